//--- logic/dncs_cfg.svh
// Purpose: offsets, field positions, reset values and codes of the channel-select block
// Assumes: byte addresses on a 32-bit register bus
// Notes: definitions only
`ifndef DNCS_CFG_SVH
`define DNCS_CFG_SVH

// ************************************************************
// register byte offsets
// ************************************************************
`define DNCS_OFF_CHAN_REG 12'h0314
`define DNCS_OFF_ROUTING 12'h0330
`define DNCS_OFF_NCO_CTRL 12'h0334
`define DNCS_OFF_STATUS 12'h0338

// ************************************************************
// field positions and reset values
// ************************************************************
`define DNCS_ROUTE_I_BIT 0
`define DNCS_ROUTE_Q_BIT 2
`define DNCS_ROUTE_RST 8'h05
`define DNCS_CTRL_RST 8'h00
`define DNCS_CHAN_RST 8'h00
`define DNCS_MODE_HI 7
`define DNCS_MODE_LO 4
`define DNCS_SLOT_HI 3
`define DNCS_SLOT_LO 0

// ************************************************************
// channel source mode codes and bus responses
// ************************************************************
`define DNCS_MODE_REG 4'h0
`define DNCS_MODE_PINS 4'h1
`define DNCS_MODE_EDGE_A 4'h8
`define DNCS_MODE_EDGE_B 4'hA
`define DNCS_RESP_OKAY 2'h0
`define DNCS_RESP_SLVERR 2'h2

`endif

//--- logic/dncs_pkg.sv
// Purpose: shared types of the channel-select block
// Assumes: codes come from dncs_cfg.svh
// Notes: no constants live here
`default_nettype none

package dncs_pkg;

  // decoded channel source, one value per documented mode
  typedef enum logic [2:0] {
    DNCS_SRC_REG,
    DNCS_SRC_PINS,
    DNCS_SRC_EDGE_A,
    DNCS_SRC_EDGE_B
  } dncs_src_e;

  typedef logic [3:0] dncs_idx_t;

endpackage

`default_nettype wire

//--- logic/dncs_top.sv
// Purpose: NCO channel select and input routing for one downconverter, AXI4-Lite slave
// Assumes: select pins are asynchronous to clk_sys; one clock, synchronous reset
// Notes:
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
`include "dncs_cfg.svh"
`default_nettype none

module dncs_top #(
  parameter int ADDR_W = 12
) (
  input wire logic clk_sys, // 200 MHz system clock
  input wire logic reset, // synchronous, active high
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic first_select_pin, // asynchronous select pin
  input wire logic second_select_pin, // asynchronous select pin
  output logic inphase_source_bit, // 0 channel A, 1 channel B
  output logic quadrature_source_bit, // 0 channel A, 1 channel B
  output logic [3:0] active_channel, // active NCO channel index
  output logic [3:0] map_slot_index, // slot exposed to per-channel registers
  output logic [15:0] map_slot_onehot // one-hot form of the exposed slot
);

  // ************************************************************
  // elaboration check
  // ************************************************************
  if (ADDR_W < 12) begin : g_addr_chk
    $error("dncs_top: ADDR_W must be at least 12");
  end

  // ************************************************************
  // functions
  // ************************************************************
  // mode field to source; unlisted codes fall back to the channel register
  function automatic dncs_pkg::dncs_src_e mode_to_src(input logic [3:0] m);
    case (m)
      `DNCS_MODE_PINS: mode_to_src = dncs_pkg::DNCS_SRC_PINS;
      `DNCS_MODE_EDGE_A: mode_to_src = dncs_pkg::DNCS_SRC_EDGE_A;
      `DNCS_MODE_EDGE_B: mode_to_src = dncs_pkg::DNCS_SRC_EDGE_B;
      default: mode_to_src = dncs_pkg::DNCS_SRC_REG;
    endcase
  endfunction

  // slot code to one-hot slot select
  function automatic logic [15:0] slot_decode(input dncs_pkg::dncs_idx_t s);
    slot_decode = 16'h0001 << s;
  endfunction

  // mapped: one of the four words, and no bit above the decoded range set (no aliasing)
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    logic [11:0] w;
    w = {a[11:2], 2'b00};
    is_mapped = (ADDR_W'(a[11:0]) == a) && ((w == `DNCS_OFF_CHAN_REG) ||
                (w == `DNCS_OFF_ROUTING) || (w == `DNCS_OFF_NCO_CTRL) || (w == `DNCS_OFF_STATUS));
  endfunction

  // ************************************************************
  // pin synchronisers and edge detect
  // ************************************************************
  logic [2:0] a_sync_r, a_sync_nxt, b_sync_r, b_sync_nxt;
  logic a_lvl_r, a_lvl_nxt, b_lvl_r, b_lvl_nxt;
  logic a_rise, b_rise;

  // the filtered level moves only when stages two and three agree
  always_comb begin
    a_sync_nxt = {a_sync_r[1:0], first_select_pin};
    b_sync_nxt = {b_sync_r[1:0], second_select_pin};
    a_lvl_nxt = (a_sync_r[1] == a_sync_r[2]) ? a_sync_r[2] : a_lvl_r;
    b_lvl_nxt = (b_sync_r[1] == b_sync_r[2]) ? b_sync_r[2] : b_lvl_r;
    a_rise = a_lvl_nxt & ~a_lvl_r;
    b_rise = b_lvl_nxt & ~b_lvl_r;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      a_sync_r <= 3'h0;
      b_sync_r <= 3'h0;
      a_lvl_r <= 1'b0;
      b_lvl_r <= 1'b0;
    end else begin
      a_sync_r <= a_sync_nxt;
      b_sync_r <= b_sync_nxt;
      a_lvl_r <= a_lvl_nxt;
      b_lvl_r <= b_lvl_nxt;
    end
  end

  // ************************************************************
  // register bus slave and register file
  // ************************************************************
  logic aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
  logic [ADDR_W-1:0] waddr_r, waddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic awready_r, awready_nxt, wready_r, wready_nxt, arready_r, arready_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [7:0] chan_r, chan_nxt, route_r, route_nxt, ctrl_r, ctrl_nxt;
  logic [3:0] cnt_r;
  logic [3:0] act_r;
  logic [11:0] waddr_w, raddr_w;

  assign waddr_w = is_mapped(waddr_r) ? {waddr_r[11:2], 2'b00} : 12'h000;
  assign raddr_w = is_mapped(s_axi_araddr) ? {s_axi_araddr[11:2], 2'b00} : 12'h000;

  // address and data are taken in either order; the write happens once both are held
  always_comb begin
    aw_have_nxt = aw_have_r;
    w_have_nxt = w_have_r;
    waddr_nxt = waddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    chan_nxt = chan_r;
    route_nxt = route_r;
    ctrl_nxt = ctrl_r;
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (s_axi_awvalid && awready_r) begin
      aw_have_nxt = 1'b1;
      waddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_r) begin
      w_have_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
    end
    if (aw_have_r && w_have_r && !bvalid_r) begin
      aw_have_nxt = 1'b0;
      w_have_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = is_mapped(waddr_r) ? `DNCS_RESP_OKAY : `DNCS_RESP_SLVERR;
      if (wstrb_r[0]) begin
        case (waddr_w)
          `DNCS_OFF_CHAN_REG: chan_nxt = {4'h0, wdata_r[3:0]};
          // reserved and out-of-scope bits stay zero
          `DNCS_OFF_ROUTING: route_nxt = wdata_r[7:0] & 8'h05;
          `DNCS_OFF_NCO_CTRL: ctrl_nxt = wdata_r[7:0];
          default: ;
        endcase
      end
    end
    awready_nxt = !aw_have_nxt;
    wready_nxt = !w_have_nxt;
  end

  // one read in flight; the next address is refused until the data is taken
  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid && arready_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = is_mapped(s_axi_araddr) ? `DNCS_RESP_OKAY : `DNCS_RESP_SLVERR;
      case (raddr_w)
        `DNCS_OFF_CHAN_REG: rdata_nxt = {24'h0000_00, chan_r};
        `DNCS_OFF_ROUTING: rdata_nxt = {24'h0000_00, route_r};
        `DNCS_OFF_NCO_CTRL: rdata_nxt = {24'h0000_00, ctrl_r};
        `DNCS_OFF_STATUS: rdata_nxt = {22'h0_0000, b_lvl_r, a_lvl_r, cnt_r, act_r};
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
    arready_nxt = !rvalid_nxt;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      waddr_r <= '0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= 2'h0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= 2'h0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      arready_r <= 1'b0;
      chan_r <= `DNCS_CHAN_RST;
      route_r <= `DNCS_ROUTE_RST;
      ctrl_r <= `DNCS_CTRL_RST;
    end else begin
      aw_have_r <= aw_have_nxt;
      w_have_r <= w_have_nxt;
      waddr_r <= waddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      arready_r <= arready_nxt;
      chan_r <= chan_nxt;
      route_r <= route_nxt;
      ctrl_r <= ctrl_nxt;
    end
  end

  // ************************************************************
  // channel counter and active channel
  // ************************************************************
  dncs_pkg::dncs_src_e src;
  logic [3:0] cnt_nxt, act_nxt, limit;
  logic [15:0] onehot_r;
  logic step;

  // a limit below the count still wraps, so a lowered limit cannot strand it
  always_comb begin
    src = mode_to_src(ctrl_r[`DNCS_MODE_HI:`DNCS_MODE_LO]);
    limit = ctrl_r[`DNCS_SLOT_HI:`DNCS_SLOT_LO];
    step = ((src == dncs_pkg::DNCS_SRC_EDGE_A) && a_rise) ||
           ((src == dncs_pkg::DNCS_SRC_EDGE_B) && b_rise);
    cnt_nxt = cnt_r;
    if (step) begin
      cnt_nxt = (cnt_r >= limit) ? 4'h0 : 4'(cnt_r + 4'h1);
    end
    case (src)
      dncs_pkg::DNCS_SRC_PINS: act_nxt = {2'b00, b_lvl_r, a_lvl_r};
      dncs_pkg::DNCS_SRC_EDGE_A: act_nxt = cnt_r;
      dncs_pkg::DNCS_SRC_EDGE_B: act_nxt = cnt_r;
      default: act_nxt = chan_r[3:0];
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cnt_r <= 4'h0;
      act_r <= 4'h0;
      onehot_r <= 16'h0001;
    end else begin
      cnt_r <= cnt_nxt;
      act_r <= act_nxt;
      onehot_r <= slot_decode(ctrl_nxt[`DNCS_SLOT_HI:`DNCS_SLOT_LO]);
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign inphase_source_bit = route_r[`DNCS_ROUTE_I_BIT];
  assign quadrature_source_bit = route_r[`DNCS_ROUTE_Q_BIT];
  assign active_channel = act_r;
  assign map_slot_index = ctrl_r[`DNCS_SLOT_HI:`DNCS_SLOT_LO];
  assign map_slot_onehot = onehot_r;

  // ************************************************************
  // assertions and covers
  // ************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  logic wr_fire;
  assign wr_fire = aw_have_r && w_have_r && !bvalid_r && wstrb_r[0];

  a_inph_route_write: assert property (wr_fire && waddr_w == `DNCS_OFF_ROUTING
    |=> inphase_source_bit == $past(wdata_r[0]))
    else $error("in-phase select did not follow the write");
  a_quad_route_write: assert property (wr_fire && waddr_w == `DNCS_OFF_ROUTING
    |=> quadrature_source_bit == $past(wdata_r[2]))
    else $error("quadrature select did not follow the write");
  a_reg_source_sel: assert property (src == dncs_pkg::DNCS_SRC_REG
    |=> active_channel == $past(chan_r[3:0]))
    else $error("active channel not taken from channel register");
  a_pin_source_sel: assert property (src == dncs_pkg::DNCS_SRC_PINS
    |=> active_channel == {2'b00, $past(b_lvl_r), $past(a_lvl_r)})
    else $error("active channel not formed from pins");
  a_edge_a_count: assert property (src == dncs_pkg::DNCS_SRC_EDGE_A && a_rise && cnt_r < limit
    |=> cnt_r == $past(cnt_r) + 4'h1 ##1 active_channel == $past(cnt_r))
    else $error("counter missed a first pin edge");
  a_edge_b_count: assert property (src == dncs_pkg::DNCS_SRC_EDGE_B && b_rise && cnt_r < limit
    |=> cnt_r == $past(cnt_r) + 4'h1)
    else $error("counter missed a second pin edge");
  a_counter_wrap_zero: assert property (step && cnt_r >= limit |=> cnt_r == 4'h0)
    else $error("counter did not wrap at limit");
  a_counter_idle_hold: assert property (!step |=> $stable(cnt_r))
    else $error("counter moved without an edge");
  a_map_slot_decode: assert property ($onehot(map_slot_onehot) &&
    map_slot_onehot[map_slot_index])
    else $error("slot decode does not match slot index");
  a_pin_sync_delay: assert property ($rose(first_select_pin) ##1 first_select_pin [*3]
    |=> a_lvl_r)
    else $error("first pin level not seen after sync delay");
  a_write_resp_time: assert property (aw_have_r && w_have_r && !bvalid_r |=> s_axi_bvalid)
    else $error("write response late");

  c_wrap_edge_a: cover property (src == dncs_pkg::DNCS_SRC_EDGE_A && step && cnt_r >= limit);
  c_pin_mode_three: cover property (src == dncs_pkg::DNCS_SRC_PINS && active_channel == 4'h3);
  c_write_done: cover property (s_axi_bvalid && s_axi_bready);
  c_read_done: cover property (s_axi_rvalid && s_axi_rready);

endmodule

`default_nettype wire

//--- sim/ddc_nco_channel_select_tb_top.sv
// Purpose: self-checking bench of the channel select and routing block
// Assumes: AXI4-Lite master driven right after rising edges of clk_sys
// Notes: byte lane 0 only; wstrb is 4'h1 except for one masked write
`timescale 1ns/1ps
`include "dncs_cfg.svh"
`default_nettype none
`define CHK(n, e, g) chk(n, 32'(e), 32'(g))

module ddc_nco_channel_select_tb_top;
  // ************************************************************
  // signals and instances
  // ************************************************************
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [11:0] s_axi_awaddr = '0;
  logic [11:0] s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic first_select_pin, second_select_pin, inphase_source_bit, quadrature_source_bit;
  logic [3:0] active_channel, map_slot_index;
  logic [15:0] map_slot_onehot;
  int n_fail = 0;
  int check_count = 0;
  logic [31:0] rd;
  logic [1:0] rsp;

  // 200 MHz system clock
  always #2.5 clk_sys = ~clk_sys;

  dncs_top #(.ADDR_W(12)) uut (
    .clk_sys, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .first_select_pin, .second_select_pin, .inphase_source_bit,
    .quadrature_source_bit, .active_channel, .map_slot_index, .map_slot_onehot
  );
  dncs_pin_drv pdrv (.clk_sys, .first_select_pin, .second_select_pin);

  // ************************************************************
  // shared tasks
  // ************************************************************
  // case equality, so an unknown never passes
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // one write; the extra edge at the end keeps drivers from colliding
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 100);
    if (s_axi_bvalid !== 1'b1) begin
      n_fail++;
      $display("ERROR bvalid expected 1 seen %b", s_axi_bvalid);
    end
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clk_sys);
  endtask

  // one read, data and response taken at the rvalid edge
  task automatic rdr(input logic [11:0] a);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 100);
    if (s_axi_rvalid !== 1'b1) begin
      n_fail++;
      $display("ERROR rvalid expected 1 seen %b", s_axi_rvalid);
    end
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk_sys);
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset();
    `CHK("inphase", 1, inphase_source_bit);
    `CHK("quad", 1, quadrature_source_bit);
    `CHK("slot", 0, map_slot_index);
    `CHK("onehot", 16'h0001, map_slot_onehot);
    `CHK("active", 0, active_channel);
    rdr(`DNCS_OFF_ROUTING);
    `CHK("routing", 32'h0000_0005, rd);
    `CHK("rresp", `DNCS_RESP_OKAY, rsp);
    rdr(`DNCS_OFF_STATUS);
    `CHK("status", 32'h0000_0000, rd);
    rdr(`DNCS_OFF_NCO_CTRL);
    `CHK("ctrl", 32'h0000_0000, rd);
  endtask

  // each route combination, reserved bits read back as zero
  task automatic t_route();
    logic [7:0] v;
    for (int k = 0; k < 4; k++) begin
      v = {5'h00, k[1], 1'b1, k[0]};
      wr(`DNCS_OFF_ROUTING, {24'h00_0000, v});
      `CHK("inphase", v[0], inphase_source_bit);
      `CHK("quad", v[2], quadrature_source_bit);
      rdr(`DNCS_OFF_ROUTING);
      `CHK("routing", v & 8'h05, rd);
    end
  endtask

  task automatic t_slot();
    // code 1111 reaches slot 15 as well
    for (int k = 0; k < 16; k++) begin
      wr(`DNCS_OFF_NCO_CTRL, k);
      `CHK("slot", k, map_slot_index);
      `CHK("onehot", 16'h0001 << k, map_slot_onehot);
    end
    rdr(`DNCS_OFF_NCO_CTRL);
    `CHK("ctrl", 32'h0000_000F, rd);
  endtask

  task automatic t_regmode();
    wr(`DNCS_OFF_CHAN_REG, 32'h0000_0009);
    wr(`DNCS_OFF_NCO_CTRL, 32'h0000_0000);
    `CHK("active", 9, active_channel);
    wr(`DNCS_OFF_CHAN_REG, 32'h0000_00F6);
    `CHK("active", 6, active_channel);
    rdr(`DNCS_OFF_CHAN_REG);
    `CHK("chan", 32'h0000_0006, rd);
  endtask

  task automatic t_pins();
    wr(`DNCS_OFF_NCO_CTRL, 32'h0000_0010);
    for (int k = 0; k < 4; k++) begin
      pdrv.set_pins(k[1], k[0]);
      `CHK("pins", k, active_channel);
    end
    pdrv.set_pins(1'b0, 1'b0);
  endtask

  // limit 3: counts 1 2 3 0 1, the other pin is ignored
  task automatic t_edge_a();
    wr(`DNCS_OFF_NCO_CTRL, 32'h0000_0083);
    `CHK("count", 0, active_channel);
    for (int i = 1; i < 6; i++) begin
      pdrv.pulse(1'b0);
      `CHK("count", i % 4, active_channel);
    end
    pdrv.pulse(1'b1);
    `CHK("count", 1, active_channel);
  endtask

  // limit 2 from count 1: counts 2 0 1
  task automatic t_edge_b();
    wr(`DNCS_OFF_NCO_CTRL, 32'h0000_00A2);
    for (int i = 2; i < 5; i++) begin
      pdrv.pulse(1'b1);
      `CHK("count", i % 3, active_channel);
    end
    pdrv.pulse(1'b0);
    `CHK("count", 1, active_channel);
    rdr(`DNCS_OFF_STATUS);
    `CHK("status", 32'h0000_0011, rd);
  endtask

  // unmapped place answers with an error and changes nothing
  task automatic t_unmapped();
    rdr(12'h100);
    `CHK("rresp", `DNCS_RESP_SLVERR, rsp);
    `CHK("rdata", 0, rd);
    wr(12'h100, 32'h0000_00FF);
    `CHK("bresp", `DNCS_RESP_SLVERR, rsp);
    // byte lane 0 masked: answered OKAY, nothing written
    s_axi_wstrb <= 4'h0;
    wr(`DNCS_OFF_NCO_CTRL, 32'h0000_0011);
    s_axi_wstrb <= 4'h1;
    `CHK("bresp", `DNCS_RESP_OKAY, rsp);
    rdr(`DNCS_OFF_NCO_CTRL);
    `CHK("ctrl", 32'h0000_00A2, rd);
  endtask

  // reset in mid-run brings registers and the counter back to their start values
  task automatic t_rereset();
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (2) @(posedge clk_sys);
    t_reset();
  endtask

  // ************************************************************
  // main sequence and watchdog
  // ************************************************************
  initial begin
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (2) @(posedge clk_sys);
    t_reset();
    t_route();
    t_slot();
    t_regmode();
    t_pins();
    t_edge_a();
    t_edge_b();
    t_unmapped();
    t_rereset();
    results();
  end

  // whole run is near 350 cycles; the 10000-cycle limit allows near thirty times that
  initial begin
    #50000;
    n_fail++;
    results();
  end
endmodule

`default_nettype wire

//--- sim/dncs_pin_drv.sv
// Purpose: model of the far logic that drives the two channel select pins
// Assumes: pins are sampled on rising edges of clk_sys through a filter
// Notes: every level is held 7 cycles, above what the filter needs
`timescale 1ns/1ps
`default_nettype none

module dncs_pin_drv (
  input wire logic clk_sys, // bench clock
  output logic first_select_pin, // first select pin
  output logic second_select_pin // second select pin
);
  // ************************************************************
  // pin driving
  // ************************************************************
  // pins idle low, so no edge is seen before the bench asks
  initial begin
    first_select_pin = 1'b0;
    second_select_pin = 1'b0;
  end

  // set both levels, then hold them so each change is seen once
  task automatic set_pins(input logic b, input logic a);
    @(posedge clk_sys);
    second_select_pin <= b;
    first_select_pin <= a;
    repeat (6) @(posedge clk_sys);
  endtask

  // one rising edge on the chosen pin, followed by a long low phase
  task automatic pulse(input logic on_b);
    set_pins(on_b, !on_b);
    set_pins(1'b0, 1'b0);
  endtask
endmodule

`default_nettype wire
